// ===== src/ppv_pkg.sv
// constants and types shared by the program/verify port
package ppv_pkg;
    localparam int ADDR_W = 15;
    localparam int MEM_DEPTH = 32640;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [1:0] LAST_PHASE = 2'h3;

    // operation codes on the select pins, bit 0 first pin
    localparam logic [3:0] SEL_CLEAR = 4'h5;
    localparam logic [3:0] SEL_WRITE = 4'he;
    localparam logic [3:0] SEL_VERIFY = 4'hc;
    localparam logic [3:0] SEL_INHIBIT_MASK = 4'hd;
    localparam logic [3:0] SEL_INHIBIT = 4'hd;

    // register byte offsets
    localparam logic [31:0] REG_CTRL = 32'h0000_0000;
    localparam logic [31:0] REG_STATUS = 32'h0000_0004;
    localparam logic [31:0] REG_ADDR = 32'h0000_0008;
    localparam logic [31:0] REG_WRITES = 32'h0000_000c;
    localparam logic [31:0] REG_MEM_ADDR = 32'h0000_0010;
    localparam logic [31:0] REG_MEM_DATA = 32'h0000_0014;

    // field positions and reset values
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_FAULT_CLR_BIT = 1;
    localparam logic CTRL_ENABLE_RESET = 1'b1;
    localparam int STATUS_ACTIVE_BIT = 0;
    localparam int STATUS_MODE_LSB = 1;
    localparam int STATUS_FAULT_BIT = 4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        MODE_IDLE = 3'b000,
        MODE_CLEAR = 3'b001,
        MODE_WRITE = 3'b010,
        MODE_VERIFY = 3'b011,
        MODE_INHIBIT = 3'b100,
        MODE_OTHER = 3'b101
    } ppv_mode_t;

    function automatic ppv_mode_t ppv_decode(input logic [3:0] sel, input logic active);
        ppv_decode = MODE_OTHER;
        if (!active) begin
            ppv_decode = MODE_IDLE;
        end else if (sel == SEL_CLEAR) begin
            ppv_decode = MODE_CLEAR;
        end else if (sel == SEL_WRITE) begin
            ppv_decode = MODE_WRITE;
        end else if (sel == SEL_VERIFY) begin
            ppv_decode = MODE_VERIFY;
        end else if ((sel & SEL_INHIBIT_MASK) == SEL_INHIBIT) begin
            ppv_decode = MODE_INHIBIT;
        end
    endfunction : ppv_decode
endpackage : ppv_pkg

// ===== src/ppv_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/100ps
module ppv_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : ppv_sync

// ===== src/ppv_step.sv
// address counter stepped by groups of clock pin pulses
`timescale 1ns/100ps
module ppv_step #(
    parameter int ADDR_W = ppv_pkg::ADDR_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic count_en,
    input wire logic pulse_rise,
    output logic [ADDR_W-1:0] addr,
    output logic [1:0] phase,
    output logic stepped
);
    wire last_pulse = count_en && pulse_rise && (phase == ppv_pkg::LAST_PHASE);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            addr <= '0;
            phase <= '0;
            stepped <= 1'b0;
        end else begin
            stepped <= last_pulse && !clear;
            if (clear) begin
                addr <= '0;
                phase <= '0;
            end else if (count_en && pulse_rise) begin
                phase <= phase + 2'h1;
                if (last_pulse) begin
                    addr <= addr + {{(ADDR_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule : ppv_step

// ===== src/ppv_port.sv
// program memory write and verify port with register access
// Function
// - address comes only from internal counter stepped by primary clock pulses
// - byte travels as low nibble on first group, high nibble on second
// - programming mode only while core and programming supplies both at level
// - select pins decode to clear, write, verify and inhibit operations
// - four primary clock pulses advance the address counter by exactly one
// - verify mode presents stored byte per four pulses, stepping through memory
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
module ppv_port #(
    parameter int ADDR_W = ppv_pkg::ADDR_W,
    parameter int MEM_DEPTH = ppv_pkg::MEM_DEPTH
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic core_supply_ok,
    input wire logic prog_supply_ok,
    input wire logic [3:0] prog_op_select_pins,
    input wire logic primary_clock_pin,
    input wire logic complement_clock_pin,
    input wire logic [3:0] data_low_nibble_pins_in,
    output logic [3:0] data_low_nibble_pins_out,
    output logic [3:0] data_low_nibble_pins_oe,
    input wire logic [3:0] data_high_nibble_pins_in,
    output logic [3:0] data_high_nibble_pins_out,
    output logic [3:0] data_high_nibble_pins_oe
);
    logic [1:0] rst_pipe;
    wire rst_n = rst_pipe[1];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    // pin synchronisers
    logic [15:0] pins_sync;
    ppv_sync #(.WIDTH(16)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in({core_supply_ok, prog_supply_ok, prog_op_select_pins, primary_clock_pin,
                   complement_clock_pin, data_high_nibble_pins_in, data_low_nibble_pins_in}),
        .sync_out(pins_sync)
    );
    wire core_ok = pins_sync[15];
    wire vpp_ok = pins_sync[14];
    wire [3:0] sel = pins_sync[13:10];
    wire pri_clk = pins_sync[9];
    wire comp_clk = pins_sync[8];
    wire [7:0] pin_byte = pins_sync[7:0];

    // control state
    logic enable;
    logic fault;
    logic pri_prev;
    logic comp_equal_prev;
    logic [ADDR_W-1:0] mem_addr;
    logic [7:0] write_entries;
    ppv_pkg::ppv_mode_t mode;
    ppv_pkg::ppv_mode_t next_mode;

    wire active = core_ok && vpp_ok && enable;
    assign next_mode = ppv_pkg::ppv_decode(sel, active);
    wire pulse_rise = pri_clk && !pri_prev;
    wire comp_equal = active && (pri_clk == comp_clk);

    logic [ADDR_W-1:0] addr;
    logic [1:0] phase;
    logic stepped;
    ppv_step #(.ADDR_W(ADDR_W)) u_step (
        .clock(clock),
        .rst_n(rst_n),
        .clear(mode == ppv_pkg::MODE_CLEAR),
        .count_en(mode != ppv_pkg::MODE_IDLE),
        .pulse_rise(pulse_rise),
        .addr(addr),
        .phase(phase),
        .stepped(stepped)
    );

    // program memory
    logic [7:0] mem [MEM_DEPTH] = '{default: ppv_pkg::ERASED_BYTE};
    wire in_range = 32'(addr) < MEM_DEPTH;
    wire sw_in_range = 32'(mem_addr) < MEM_DEPTH;
    wire [7:0] read_byte = in_range ? mem[addr] : ppv_pkg::ERASED_BYTE;
    wire [7:0] sw_byte = sw_in_range ? mem[mem_addr] : ppv_pkg::ERASED_BYTE;
    // write programs zeros while mode persists
    wire wr_en = (mode == ppv_pkg::MODE_WRITE) && in_range;

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[addr] <= read_byte & pin_byte;
        end
    end

    // data pins driven only in verify
    wire drive = (mode == ppv_pkg::MODE_VERIFY);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_low_nibble_pins_out <= 4'h0;
            data_high_nibble_pins_out <= 4'h0;
            data_low_nibble_pins_oe <= 4'h0;
            data_high_nibble_pins_oe <= 4'h0;
        end else begin
            data_low_nibble_pins_out <= read_byte[3:0];
            data_high_nibble_pins_out <= read_byte[7:4];
            data_low_nibble_pins_oe <= {4{drive}};
            data_high_nibble_pins_oe <= {4{drive}};
        end
    end

    // axi write channel capture
    logic aw_hold;
    logic w_hold;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready = !w_hold && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    wire do_write = aw_hold && w_hold && !s_axi_bvalid;
    wire wr_ctrl = do_write && (aw_addr == ppv_pkg::REG_CTRL) && w_strb[0];
    wire wr_mem_addr = do_write && (aw_addr == ppv_pkg::REG_MEM_ADDR);
    wire wr_mapped = (aw_addr == ppv_pkg::REG_CTRL) || (aw_addr == ppv_pkg::REG_MEM_ADDR);
    wire fault_clr = wr_ctrl && w_data[ppv_pkg::CTRL_FAULT_CLR_BIT];
    wire [ADDR_W-1:0] next_mem_addr = {(w_strb[1] ? w_data[ADDR_W-1:8] : mem_addr[ADDR_W-1:8]),
                                       (w_strb[0] ? w_data[7:0] : mem_addr[7:0])};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ppv_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= {s_axi_awaddr[31:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? ppv_pkg::RESP_OKAY : ppv_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register state; fault set wins over clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            enable <= ppv_pkg::CTRL_ENABLE_RESET;
            fault <= 1'b0;
            mem_addr <= '0;
            mode <= ppv_pkg::MODE_IDLE;
            pri_prev <= 1'b0;
            comp_equal_prev <= 1'b0;
            write_entries <= 8'h00;
        end else begin
            mode <= next_mode;
            pri_prev <= pri_clk;
            comp_equal_prev <= comp_equal;
            if (wr_ctrl) begin
                enable <= w_data[ppv_pkg::CTRL_ENABLE_BIT];
            end
            if (wr_mem_addr) begin
                mem_addr <= next_mem_addr;
            end
            if (comp_equal && comp_equal_prev) begin
                fault <= 1'b1;
            end else if (fault_clr) begin
                fault <= 1'b0;
            end
            if (next_mode == ppv_pkg::MODE_WRITE && mode != ppv_pkg::MODE_WRITE) begin
                write_entries <= (stepped || mode == ppv_pkg::MODE_CLEAR) ? 8'h01 : write_entries + 8'h01;
            end else if (stepped || mode == ppv_pkg::MODE_CLEAR) begin
                write_entries <= 8'h00;
            end
        end
    end

    // axi read channel
    logic [31:0] rd_word;
    logic rd_mapped;
    wire [31:0] ar_addr = {s_axi_araddr[31:2], 2'h0};
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_mapped = 1'b1;
        unique case (ar_addr)
            ppv_pkg::REG_CTRL: rd_word[ppv_pkg::CTRL_ENABLE_BIT] = enable;
            ppv_pkg::REG_STATUS: rd_word[4:0] = {fault, mode, active};
            ppv_pkg::REG_ADDR: rd_word[ADDR_W+1:0] = {addr, phase};
            ppv_pkg::REG_WRITES: rd_word[7:0] = write_entries;
            ppv_pkg::REG_MEM_ADDR: rd_word[ADDR_W-1:0] = mem_addr;
            ppv_pkg::REG_MEM_DATA: rd_word[7:0] = sw_byte;
            default: rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ppv_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_mapped ? ppv_pkg::RESP_OKAY : ppv_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    sequence seq_last_pulse;
        pulse_rise && phase == ppv_pkg::LAST_PHASE && mode != ppv_pkg::MODE_CLEAR
            && mode != ppv_pkg::MODE_IDLE;
    endsequence

    sequence seq_early_pulse;
        pulse_rise && phase != ppv_pkg::LAST_PHASE && mode != ppv_pkg::MODE_CLEAR;
    endsequence

    sequence seq_verify_hold;
        mode == ppv_pkg::MODE_VERIFY ##1 mode == ppv_pkg::MODE_VERIFY && $stable(addr);
    endsequence

    chk_step_after_four: assert property (@(posedge clock) disable iff (!rst_n)
        seq_last_pulse |=> addr == $past(addr) + 1'b1 && phase == 2'h0)
        else $error("address did not advance after fourth pulse");

    chk_no_early_step: assert property (@(posedge clock) disable iff (!rst_n)
        seq_early_pulse |=> addr == $past(addr))
        else $error("address moved before fourth pulse");

    chk_clear_zeroes: assert property (@(posedge clock) disable iff (!rst_n)
        mode == ppv_pkg::MODE_CLEAR |=> addr == '0 && phase == 2'h0)
        else $error("clear mode did not zero address");

    chk_supply_gate: assert property (@(posedge clock) disable iff (!rst_n)
        !(core_ok && vpp_ok) |=> mode == ppv_pkg::MODE_IDLE)
        else $error("mode active without both supplies");

    chk_verify_data: assert property (@(posedge clock) disable iff (!rst_n)
        seq_verify_hold |-> {data_high_nibble_pins_out, data_low_nibble_pins_out} == $past(read_byte)
            && data_low_nibble_pins_oe == 4'hf)
        else $error("verify did not present stored byte");

    chk_drive_verify: assert property (@(posedge clock) disable iff (!rst_n)
        (data_high_nibble_pins_oe != 4'h0) |-> $past(mode) == ppv_pkg::MODE_VERIFY)
        else $error("data driven outside verify");

    chk_inhibit_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        mode == ppv_pkg::MODE_INHIBIT && !pulse_rise |=> addr == $past(addr)
            && mem[$past(addr)] == $past(read_byte) && data_low_nibble_pins_oe == 4'h0)
        else $error("inhibit changed address, memory or drive");

    chk_write_program: assert property (@(posedge clock) disable iff (!rst_n)
        mode == ppv_pkg::MODE_WRITE && in_range |=> mem[$past(addr)] == $past(read_byte & pin_byte))
        else $error("write mode did not program byte");

    chk_bvalid_hold: assert property (@(posedge clock) disable iff (!rst_n)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
endmodule : ppv_port

// ===== dv/ppv_programmer.sv
// programmer model for the select, clock and data pins
`timescale 1ns/100ps
module ppv_programmer #(
    parameter int PULSE_CYC = 20,
    parameter int MAX_TRIES = 3
) (
    input wire logic clock,
    input wire logic [7:0] pins_seen,
    output logic core_ok,
    output logic prog_ok,
    output logic [3:0] sel,
    output logic clk_p,
    output logic clk_n,
    output logic [7:0] data
);
    logic drive;
    logic [7:0] wr_byte;
    logic [7:0] noise;
    initial begin
        core_ok = 1'b0;
        prog_ok = 1'b0;
        sel = 4'h0;
        clk_p = 1'b0;
        drive = 1'b0;
        wr_byte = 8'hff;
        noise = 8'h00;
    end
    assign clk_n = ~clk_p;
    // byte on both nibble groups, pattern when released
    assign data = drive ? wr_byte : noise;
    always @(posedge clock) begin
        noise <= noise + 8'h3b;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : wait_cyc
    task automatic set_sel(input logic [3:0] code);
        @(posedge clock);
        sel <= code;
        wait_cyc(6);
    endtask : set_sel
    task automatic drive_byte(input logic [7:0] b, input logic en);
        @(posedge clock);
        wr_byte <= b;
        drive <= en;
    endtask : drive_byte
    task automatic pulse4();
        repeat (4) begin
            @(posedge clock);
            clk_p <= 1'b1;
            wait_cyc(3);
            clk_p <= 1'b0;
            wait_cyc(3);
        end
        wait_cyc(4);
    endtask : pulse4
    // wait, select clear, raise supplies, settle
    task automatic power_up();
        wait_cyc(200);
        set_sel(ppv_pkg::SEL_CLEAR);
        core_ok <= 1'b1;
        prog_ok <= 1'b1;
        wait_cyc(6);
    endtask : power_up
    task automatic write_pulse(input logic [7:0] b, input int n);
        drive_byte(b, 1'b1);
        sel <= ppv_pkg::SEL_WRITE;
        wait_cyc(n + 3);
        sel <= ppv_pkg::SEL_INHIBIT;
        wait_cyc(4);
        drive <= 1'b0;
    endtask : write_pulse
    // retry until match or MAX_TRIES tries, then extra write
    task automatic program_byte(input logic [7:0] b, output int tries);
        tries = 0;
        do begin
            set_sel(ppv_pkg::SEL_INHIBIT);
            tries++;
            write_pulse(b, PULSE_CYC);
            set_sel(ppv_pkg::SEL_VERIFY);
        end while (pins_seen !== b && tries < MAX_TRIES);
        set_sel(ppv_pkg::SEL_INHIBIT);
        write_pulse(b, PULSE_CYC * tries);
        set_sel(ppv_pkg::SEL_INHIBIT);
        pulse4();
    endtask : program_byte
    task automatic power_down();
        set_sel(ppv_pkg::SEL_CLEAR);
        core_ok <= 1'b0;
        prog_ok <= 1'b0;
    endtask : power_down
endmodule : ppv_programmer

// ===== dv/prom_program_verify_port_bench.sv
// self-checking bench for the program and verify port
`timescale 1ns/100ps
module prom_program_verify_port_bench;
    localparam int N_BYTES = 6;
    localparam int MAX_TRIES = 3;
    localparam logic [1:0] OK = ppv_pkg::RESP_OKAY;
    logic clock;
    logic rstn;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb, sel, lo_out, lo_oe, hi_out, hi_oe;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic core_ok, prog_ok, clk_p, clk_n;
    logic [7:0] pdata, pins;
    int bad_count, total_checks, tries, exp_b;
    integer seed = 32'h17a2_9a1e;
    int model_mem [8];
    logic [3:0] codes [6] = '{4'he, 4'hd, 4'hf, 4'h0, 4'hc, 4'h5};
    logic [2:0] modes [6] = '{3'h2, 3'h4, 3'h4, 3'h5, 3'h3, 3'h1};
    assign pins = ({hi_oe, lo_oe} & {hi_out, lo_out}) | (~{hi_oe, lo_oe} & pdata);
    ppv_port dut (.clock(clock), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_supply_ok(core_ok),
        .prog_supply_ok(prog_ok), .prog_op_select_pins(sel), .primary_clock_pin(clk_p),
        .complement_clock_pin(clk_n), .data_low_nibble_pins_in(pins[3:0]), .data_low_nibble_pins_out(lo_out),
        .data_low_nibble_pins_oe(lo_oe), .data_high_nibble_pins_in(pins[7:4]),
        .data_high_nibble_pins_out(hi_out), .data_high_nibble_pins_oe(hi_oe));
    ppv_programmer #(.PULSE_CYC(20), .MAX_TRIES(MAX_TRIES)) prog (.clock(clock), .pins_seen(pins),
        .core_ok(core_ok), .prog_ok(prog_ok), .sel(sel), .clk_p(clk_p), .clk_n(clk_n), .data(pdata));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic wr_chk(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clock);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'($random(seed));
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid === 1'b1 && bready !== 1'b1) bready <= 1'b1;
        end while (bvalid !== 1'b1 || bready !== 1'b1);
        bready <= 1'b0;
        check({34'h0_0000_0000, bresp}, {34'h0_0000_0000, r});
    endtask : wr_chk
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        check({2'b00, rresp, rdata}, {2'b00, r, d});
    endtask : rd_chk
    task automatic prog_at(input int i, input logic [7:0] v);
        prog.program_byte(v, tries);
        exp_b = model_mem[i] & v;
        check(36'(tries), (exp_b == v) ? 36'h1 : 36'(MAX_TRIES));
        model_mem[i] = exp_b;
        rd_chk(ppv_pkg::REG_ADDR, 32'(i + 1) << 2, OK);
        wr_chk(ppv_pkg::REG_MEM_ADDR, 32'(i), OK);
        rd_chk(ppv_pkg::REG_MEM_DATA, 32'(exp_b), OK);
    endtask : prog_at
    initial begin
        repeat (60000) @(posedge clock);
        bad_count++;
        report_and_stop();
    end
    initial begin
        rstn = 1'b0;
        {awaddr, wdata, araddr, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        bad_count = 0;
        total_checks = 0;
        foreach (model_mem[i]) model_mem[i] = 255;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        rd_chk(ppv_pkg::REG_CTRL, 32'h0000_0001, OK);
        prog.write_pulse(8'h00, 20);
        rd_chk(ppv_pkg::REG_STATUS, 32'h0000_0000, OK);
        rd_chk(ppv_pkg::REG_MEM_DATA, 32'h0000_00ff, OK);
        rd_chk(32'h0000_0040, 32'h0000_0000, ppv_pkg::RESP_SLVERR);
        wr_chk(ppv_pkg::REG_STATUS, 32'h0000_0000, ppv_pkg::RESP_SLVERR);
        prog.power_up();
        for (int i = 0; i < 6; i++) begin
            prog.drive_byte(8'hff, i < 4);
            prog.set_sel(codes[i]);
            rd_chk(ppv_pkg::REG_STATUS, {28'h000_0000, modes[i], 1'b1}, OK);
            rd_chk(ppv_pkg::REG_WRITES, (i < 5) ? 32'h0000_0001 : 32'h0000_0000, OK);
            check({28'h000_0000, hi_oe, lo_oe}, (i == 4) ? 36'h0_0000_00ff : 36'h0);
        end
        for (int i = 0; i < N_BYTES; i++) prog_at(i, 8'($random(seed)));
        prog.set_sel(ppv_pkg::SEL_CLEAR);
        rd_chk(ppv_pkg::REG_ADDR, 32'h0000_0000, OK);
        prog.set_sel(ppv_pkg::SEL_INHIBIT);
        check({28'h000_0000, hi_oe, lo_oe}, 36'h0);
        prog.set_sel(ppv_pkg::SEL_VERIFY);
        for (int i = 0; i < N_BYTES; i++) begin
            check({28'h000_0000, pins}, 36'(model_mem[i]));
            prog.pulse4();
        end
        prog.set_sel(ppv_pkg::SEL_CLEAR);
        prog_at(0, ~8'(model_mem[0]) | 8'($random(seed)));
        prog.wait_cyc(40);
        rd_chk(ppv_pkg::REG_ADDR, 32'h0000_0004, OK);
        wr_chk(ppv_pkg::REG_CTRL, 32'h0000_0000, OK);
        rd_chk(ppv_pkg::REG_STATUS, 32'h0000_0000, OK);
        wr_chk(ppv_pkg::REG_CTRL, 32'h0000_0001, OK);
        rd_chk(ppv_pkg::REG_STATUS, 32'h0000_0009, OK);
        prog.power_down();
        prog.wait_cyc(6);
        rd_chk(ppv_pkg::REG_STATUS, 32'h0000_0000, OK);
        report_and_stop();
    end
endmodule : prom_program_verify_port_bench
